/* File: design/sram_ctrl_consts.vh */
`ifndef SRAM_CTRL_CONSTS_VH
`define SRAM_CTRL_CONSTS_VH
// ==========================================
// Timing figures in ns and clock period
`define CLK_PERIOD_NS 8
`define T_RC_NS 70
`define T_AA_NS 70
`define T_WC_NS 70
`define T_WP_NS 50
`define T_DW_NS 30
// Least times round up to whole cycles
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_CYCLES `CYC_UP(`T_AA_NS)
`define WP_CYCLES `CYC_UP(`T_WP_NS)
`define REC_CYCLES 1
`define SYNC_STAGES 2
`define CNT_STEP 1
`define LANES_ALL 2'h3
`define CNT_W 4
`endif

/* File: design/sram_host_ctrl.v */
`timescale 1ns/10ps
`include "sram_ctrl_consts.vh"

module sram_host_ctrl #(
    parameter AW = 19,
    parameter DW = 16
) (
    input wire clock, // System clock
    input wire rst, // Sync reset, active high
    input wire req_valid, // Request pulse or level
    input wire req_write, // 1 write, 0 read
    input wire [AW-1:0] req_addr, // Word address
    input wire [DW-1:0] req_wdata, // Write data
    input wire [1:0] req_lanes, // Lane select, bit1 upper
    input wire word_mode, // Width select wanted
    output reg req_ready, // Idle, request accepted
    output reg rsp_valid, // Read data pulse
    output reg [DW-1:0] rsp_rdata, // Read data
    output reg [AW-1:0] sram_addr, // Address pins
    output reg sram_primary_select_n, // Primary chip enable
    output reg sram_secondary_select_hi, // Secondary chip enable
    output reg write_strobe_n, // Write strobe
    output reg output_enable_n, // Output enable
    output reg upper_lane_enable_n, // Upper lane enable
    output reg lower_lane_enable_n, // Lower lane enable
    output reg bus_width_select, // Width select
    input wire [DW-1:0] data_in, // Data pins in
    output reg [DW-1:0] data_out, // Data pins out
    output reg data_oe_n // Data drive enable, low drives
);

    // ==========================================
    // States
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_READ = 4'h2;
    localparam [3:0] ST_WRITE = 4'h4;
    localparam [3:0] ST_REC = 4'h8;

    // Sequencer state and cycle counter
    reg [3:0] state;
    reg [`CNT_W-1:0] count;
    // Two stage sync of the data pins
    reg [DW-1:0] data_sync1;
    reg [DW-1:0] data_sync2;
    reg is_write;
    // Decoded pin levels for a new request
    reg next_width;
    reg next_upper_n;
    reg next_lower_n;

    // Cycle count as a narrow constant
    function [`CNT_W-1:0] cyc;
        input integer n;
        begin
            cyc = n[`CNT_W-1:0];
        end
    endfunction

    // Lane enable level, forced on when lanes are not used
    function lane_level_n;
        input lane_wanted;
        input use_lanes;
        begin
            lane_level_n = ~(lane_wanted | ~use_lanes);
        end
    endfunction

    // Counter sits on its last cycle
    function count_done;
        input [`CNT_W-1:0] value;
        begin
            count_done = (value == cyc(`CNT_STEP));
        end
    endfunction

    // ==========================================
    // Data input synchroniser
    always @(posedge clock)
    begin
        data_sync1 <= data_in;
        data_sync2 <= data_sync1;
    end

    // ==========================================
    // Lane and width decode of the request
    // lanes and width level
    always @*
    begin
        next_width = word_mode | (req_lanes != `LANES_ALL);
        next_upper_n = lane_level_n(req_lanes[1], word_mode);
        next_lower_n = lane_level_n(req_lanes[0], word_mode);
    end

    // ==========================================
    // Main sequencer
    always @(posedge clock)
    begin
        if (rst)
        begin
            // Park the bus: selects off, strobes high, host off the data lines
            state <= ST_IDLE;
            count <= {`CNT_W{1'h0}};
            is_write <= 1'h0;
            req_ready <= 1'h0;
            rsp_valid <= 1'h0;
            rsp_rdata <= {DW{1'h0}};
            sram_addr <= {AW{1'h0}};
            sram_primary_select_n <= 1'h1;
            sram_secondary_select_hi <= 1'h0;
            write_strobe_n <= 1'h1;
            output_enable_n <= 1'h1;
            upper_lane_enable_n <= 1'h1;
            lower_lane_enable_n <= 1'h1;
            bus_width_select <= 1'h1;
            data_out <= {DW{1'h0}};
            data_oe_n <= 1'h1;
        end
        else
        begin
            // Read data pulse lasts one cycle
            rsp_valid <= 1'h0;
            case (state)
                ST_IDLE:
                begin
                    // Ready shows one cycle after entering idle
                    req_ready <= 1'h1;
                    if (req_valid && req_ready)
                    begin
                        req_ready <= 1'h0;
                        is_write <= req_write;
                        sram_addr <= req_addr;
                        sram_primary_select_n <= 1'h0;
                        sram_secondary_select_hi <= 1'h1;
                        bus_width_select <= next_width;
                        upper_lane_enable_n <= next_upper_n;
                        lower_lane_enable_n <= next_lower_n;
                        // Strobe or output enable picks the direction
                        if (req_write)
                        begin
                            write_strobe_n <= 1'h0;
                            output_enable_n <= 1'h1;
                            data_out <= req_wdata;
                            data_oe_n <= 1'h0;
                            count <= cyc(`WP_CYCLES);
                            state <= ST_WRITE;
                        end
                        else
                        begin
                            write_strobe_n <= 1'h1;
                            output_enable_n <= 1'h0;
                            data_oe_n <= 1'h1;
                            // Access time plus the input sync stages
                            count <= cyc(`RD_CYCLES + `SYNC_STAGES);
                            state <= ST_READ;
                        end
                    end
                end
                ST_READ:
                begin
                    count <= count - cyc(`CNT_STEP);
                    if (count_done(count))
                    begin
                        // Synced data has settled by now
                        rsp_rdata <= data_sync2;
                        rsp_valid <= 1'h1;
                        output_enable_n <= 1'h1;
                        sram_primary_select_n <= 1'h1;
                        count <= cyc(`REC_CYCLES);
                        state <= ST_REC;
                    end
                end
                ST_WRITE:
                begin
                    // Strobe held low for the pulse count
                    count <= count - cyc(`CNT_STEP);
                    if (count_done(count))
                    begin
                        write_strobe_n <= 1'h1;
                        count <= cyc(`REC_CYCLES);
                        state <= ST_REC;
                    end
                end
                ST_REC:
                begin
                    // Hold data one cycle past strobe
                    count <= count - cyc(`CNT_STEP);
                    if (count_done(count))
                    begin
                        sram_primary_select_n <= 1'h1;
                        upper_lane_enable_n <= 1'h1;
                        lower_lane_enable_n <= 1'h1;
                        bus_width_select <= 1'h1;
                        if (is_write)
                        begin
                            data_oe_n <= 1'h1;
                        end
                        state <= ST_IDLE;
                    end
                end
                default:
                begin
                    // Unknown code falls back to idle
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: test/sram_host_ctrl_monitor.sv */
`timescale 1ns/10ps
// ====
// Pin order checker
module sram_host_ctrl_monitor (
    input wire clock, // Clock
    input wire rst, // Reset
    input wire req_valid, // Request
    input wire req_write, // Write
    input wire req_ready, // Idle
    input wire word_mode, // Lanes used
    input wire [1:0] req_lanes, // Lanes
    input wire rsp_valid, // Read done
    input wire sram_primary_select_n, // Select
    input wire sram_secondary_select_hi, // Select
    input wire write_strobe_n, // Strobe
    input wire output_enable_n, // Output enable
    input wire upper_lane_enable_n, // Upper lane
    input wire lower_lane_enable_n, // Lower lane
    input wire bus_width_select, // Width
    input wire data_oe_n // Host drive
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Seven strobe cycles then release
    sequence s_pulse;
        !write_strobe_n [*7] ##1 write_strobe_n;
    endsequence
    a_strobe_sel:
    assert property (!write_strobe_n |-> !sram_primary_select_n && sram_secondary_select_hi) else $error("bad sel");
    a_strobe_lane:
    assert property (!write_strobe_n |-> !(upper_lane_enable_n && lower_lane_enable_n)) else $error("no lane");
    a_pulse_len:
    assert property (req_valid && req_ready && req_write |=> s_pulse) else $error("bad pulse");
    a_lane_map:
    assert property (req_valid && req_ready && word_mode |=>
        {upper_lane_enable_n, lower_lane_enable_n} == ~$past(req_lanes)) else $error("bad lanes");
    a_width_high:
    assert property (req_valid && req_ready && word_mode |=> bus_width_select) else $error("bad width");
    a_read_pins:
    assert property (!output_enable_n |-> write_strobe_n && !sram_primary_select_n && sram_secondary_select_hi
        && data_oe_n) else $error("bad read");
    a_host_drive:
    assert property (!write_strobe_n |-> !data_oe_n) else $error("no drive");
    a_read_time:
    assert property (req_valid && req_ready && !req_write |-> ##12 rsp_valid) else $error("late data");
endmodule
bind sram_host_ctrl sram_host_ctrl_monitor u_mon (.*);

/* File: test/sram_host_ctrl_tb.sv */
`timescale 1ns/10ps
// ====
// Bench
module sram_host_ctrl_tb;
    logic clock = 0, rst = 1, req_valid = 0, req_write = 0, word_mode = 1;
    logic [18:0] req_addr = 19'h0;
    logic [15:0] req_wdata = 16'h0;
    logic [1:0] req_lanes = 2'h3;
    wire req_ready, rsp_valid, sel_n, sec, we_n, oe_n, ub_n, lb_n, cio, doe_n;
    wire [15:0] rsp_rdata, din, dout;
    wire [18:0] sa;
    int mismatches = 0, checks = 0;
    // Rows: write, addr, data, lanes, mode, read value
    logic [39:0] rows [10] = '{{1'b1, 4'h1, 16'h1234, 2'h3, 1'b1, 16'h0}, {1'b1, 4'h1, 16'h56ab, 2'h1, 1'b1, 16'h0},
        {1'b0, 4'h1, 16'h0, 2'h3, 1'b1, 16'h12ab}, {1'b1, 4'h2, 16'hcdef, 2'h2, 1'b1, 16'h0},
        {1'b1, 4'h3, 16'h9876, 2'h0, 1'b0, 16'h0}, {1'b0, 4'h3, 16'h0, 2'h0, 1'b0, 16'h9876},
        {1'b0, 4'h2, 16'h0, 2'h3, 1'b0, 16'hcd00}, {1'b1, 4'h3, 16'h4321, 2'h3, 1'b0, 16'h0},
        {1'b0, 4'h3, 16'h0, 2'h3, 1'b1, 16'h4321}, {1'b0, 4'h1, 16'h0, 2'h1, 1'b1, 16'hedab}};
    always #4 clock = ~clock;
    sram_host_ctrl DUT (.clock(clock), .rst(rst), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_lanes(req_lanes), .word_mode(word_mode), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sram_addr(sa), .sram_primary_select_n(sel_n),
        .sram_secondary_select_hi(sec), .write_strobe_n(we_n), .output_enable_n(oe_n), .upper_lane_enable_n(ub_n),
        .lower_lane_enable_n(lb_n), .bus_width_select(cio), .data_in(din), .data_out(dout), .data_oe_n(doe_n));
    sram_model u_ram (.sel_n(sel_n), .sec(sec), .we_n(we_n), .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n), .cio(cio),
        .a(sa[3:0]), .din(dout), .dout(din));
    // Count and report one compare
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One request, bounded waits
    task op(input logic [39:0] r);
        int n;
        @(negedge clock);
        {req_write, req_addr, req_wdata, req_lanes, word_mode} = {r[39], 15'h0, r[38:17], r[16]};
        req_valid = 1;
        for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge clock);
        if (n == 40) chk("ready wait", 16'h0, 16'h1);
        if (n == 40) conclude;
        @(negedge clock);
        req_valid = 0;
        // Look at the one-cycle read pulse between edges
        for (n = 0; n < 40 && !r[39] && rsp_valid !== 1'b1; n++) @(negedge clock);
        if (n == 40) chk("wait", 16'h0, 16'h1);
        if (!r[39]) chk("read data", r[15:0], rsp_rdata);
        if (n == 40) conclude;
    endtask
    initial
    begin
        repeat (10) @(negedge clock);
        rst = 0;
        for (int i = 0; i < 10; i++) op(rows[i]);
        @(negedge clock);
        {req_write, req_addr[3:0], req_wdata, req_valid} = {1'b1, 4'h4, 16'h5a5a, 1'b1};
        repeat (4) @(negedge clock);
        rst = 1;
        @(negedge clock);
        chk("pins in reset", 16'h1, {15'h0, we_n & sel_n & doe_n & ~req_ready});
        {rst, req_valid} = 2'b00;
        // Cut write leaves other words intact
        op({1'b0, 4'h1, 16'h0, 2'h3, 1'b1, 16'h12ab});
        conclude;
    end
endmodule

/* File: test/sram_model.sv */
`timescale 1ns/10ps
// ====
// Static RAM model
module sram_model (
    input wire sel_n, sec, we_n, oe_n, ub_n, lb_n, cio, // Pins
    input wire [3:0] a, // Address
    input wire [15:0] din, // Host data
    output wire [15:0] dout // Device data
);
    reg [15:0] mem [0:15];
    wire ue = !cio || !ub_n;
    wire le = !cio || !lb_n;
    wire wr = !sel_n && sec && !we_n && (ue || le);
    wire rd = !sel_n && sec && !oe_n && we_n;
    initial for (int i = 0; i < 16; i++) mem[i] = 16'h0;
    always @(negedge wr)
    begin
        if (ue) mem[a][15:8] = din[15:8];
        if (le) mem[a][7:0] = din[7:0];
    end
    assign dout = {rd && ue ? mem[a][15:8] : ~mem[a][15:8], rd && le ? mem[a][7:0] : ~mem[a][7:0]};
endmodule
